/* File: pedkr_consts.svh */
// Constants for the two-port I/O block: register offsets, field
// positions, reset values and filter timing.
// Assumes inclusion by bare name from the package and the port module.
`ifndef PEDKR_CONSTS_SVH
`define PEDKR_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses on the register port)
// ----------------------------------------------------------------
`define PEDKR_OFS_PORT0_INPUT_LEVEL 16'h5200
`define PEDKR_OFS_PORT0_OUTPUT_VALUE 16'h5201
`define PEDKR_OFS_PORT0_DRIVE_ENABLE 16'h5202
`define PEDKR_OFS_PORT0_PULLUP_ENABLE 16'h5203
`define PEDKR_OFS_P0_IE 16'h5205
`define PEDKR_OFS_PORT0_IRQ_POLARITY 16'h5206
`define PEDKR_OFS_P0_PEND 16'h5207
`define PEDKR_OFS_PORT0_DEBOUNCE_CTRL 16'h5208
`define PEDKR_OFS_P0_KEY 16'h5209
`define PEDKR_OFS_PORT0_SENSE_ENABLE 16'h520A
`define PEDKR_OFS_PORT1_INPUT_LEVEL 16'h5210
`define PEDKR_OFS_PORT1_OUTPUT_VALUE 16'h5211
`define PEDKR_OFS_PORT1_DRIVE_ENABLE 16'h5212
`define PEDKR_OFS_PORT1_PULLUP_ENABLE 16'h5213
`define PEDKR_OFS_PORT1_SENSE_ENABLE 16'h521A
`define PEDKR_OFS_MUX0 16'h52A0
`define PEDKR_OFS_MUX1 16'h52A1
`define PEDKR_OFS_MUX2 16'h52A2

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PEDKR_CHAT_LO_POS 0
`define PEDKR_CHAT_HI_POS 4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PEDKR_RST_ZERO8 8'h00
`define PEDKR_RST_ZERO4 4'h0
`define PEDKR_RST_PU0 8'hFF
`define PEDKR_RST_PU1 4'hF
`define PEDKR_RST_IEN0 8'hFF
`define PEDKR_RST_IEN1 4'hF
// Input path starts at the pulled-up idle level so reset makes no edge
`define PEDKR_RST_IDLE8 8'hFF
`define PEDKR_RST_IDLE4 4'hF

// ----------------------------------------------------------------
// Filter timing: shortest check time in clock periods
// ----------------------------------------------------------------
`define PEDKR_CHECK_BASE_CYC 256

`endif

/* File: pedkr_pkg.sv */
// Types for the two-port I/O block: the whole register state.
// Assumes pedkr_consts.svh is on the include path.
`include "pedkr_consts.svh"

package pedkr_pkg;

	// Complete state of the port block
	typedef struct packed {
		logic [7:0] s1_p0;
		logic [7:0] s2_p0;
		logic [3:0] s1_p1;
		logic [3:0] s2_p1;
		logic [7:0] filt;
		logic [7:0] samp;
		logic [14:0] cnt_lo;
		logic [14:0] cnt_hi;
		logic [7:0] out0;
		logic [7:0] oen0;
		logic [7:0] pu0;
		logic [7:0] ien0;
		logic [3:0] out1;
		logic [3:0] oen1;
		logic [3:0] pu1;
		logic [3:0] ien1;
		logic [7:0] ie;
		logic [7:0] edge_sel;
		logic [7:0] pend;
		logic [7:0] chat;
		logic [1:0] key_sel;
		logic [7:0] mux0;
		logic [7:0] mux1;
		logic [7:0] mux2;
		logic [7:0] rdata;
		logic keyrst;
	} pedkr_state_s;

	// Reset image of the state
	localparam pedkr_state_s PEDKR_RST = '{
		s1_p0: `PEDKR_RST_IDLE8,
		s2_p0: `PEDKR_RST_IDLE8,
		s1_p1: `PEDKR_RST_IDLE4,
		s2_p1: `PEDKR_RST_IDLE4,
		filt: `PEDKR_RST_IDLE8,
		samp: `PEDKR_RST_IDLE8,
		cnt_lo: 15'h0000,
		cnt_hi: 15'h0000,
		out0: `PEDKR_RST_ZERO8,
		oen0: `PEDKR_RST_ZERO8,
		pu0: `PEDKR_RST_PU0,
		ien0: `PEDKR_RST_IEN0,
		out1: `PEDKR_RST_ZERO4,
		oen1: `PEDKR_RST_ZERO4,
		pu1: `PEDKR_RST_PU1,
		ien1: `PEDKR_RST_IEN1,
		ie: `PEDKR_RST_ZERO8,
		edge_sel: `PEDKR_RST_ZERO8,
		pend: `PEDKR_RST_ZERO8,
		chat: `PEDKR_RST_ZERO8,
		key_sel: 2'h0,
		mux0: `PEDKR_RST_ZERO8,
		mux1: `PEDKR_RST_ZERO8,
		mux2: `PEDKR_RST_ZERO8,
		rdata: `PEDKR_RST_ZERO8,
		keyrst: 1'b0
	};

endpackage : pedkr_pkg

/* File: pedkr_port.sv */
// A byte-wide port 0 and a four-bit port 1, general-purpose, with edge interrupts on port 0,
// a chattering filter per nibble of port 0 and a key-entry reset.
// Assumes pins synchronous-sampled on ref_clk, a one-cycle register
// port, and an external controller taking irq_req and key_reset_req.
//
// Behaviour
// - Per-pin enable gates port 0 interrupts
// - Edge select: 1 falling, 0 rising
// - Selected edge sets pin pending flag
// - Enabled pending flag raises request immediately
// - Eight sources merged into one request
// - Write one clears pending, zero keeps
// - Nibble filter codes: off, 256..16384
// - Pulses up to check time rejected
// - Selected pins all low request reset
// - Key select picks off, pins 0..1, 0..2, 0..3
// - Read-back is pin level gated
// - Input data register is read-only
// - Port 1 upper four bits read zero
// - Drive enable drives pin, else floating
// - Reset: drive off, pull-up on, data zero
`timescale 1ns/1ps
`include "pedkr_consts.svh"

module pedkr_port #(
	parameter int FILT_BASE_CYC = `PEDKR_CHECK_BASE_CYC
) (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic [15:0] bus_addr,
	input wire logic [7:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output logic [7:0] bus_rdata,
	input wire logic [7:0] p0_pin_in,
	output logic [7:0] p0_pin_out,
	output logic [7:0] p0_pin_oe_n,
	output logic [7:0] p0_pullup_on,
	input wire logic [3:0] p1_pin_in,
	output logic [3:0] p1_pin_out,
	output logic [3:0] p1_pin_oe_n,
	output logic [3:0] p1_pullup_on,
	output logic irq_req,
	output logic key_reset_req
);

	// ------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------

	// Check time in cycles for a non-zero filter code
	function automatic logic [14:0] filt_limit(input logic [2:0] code);
		logic [2:0] sh;
		sh = 3'(code - 3'h1);
		return 15'(FILT_BASE_CYC << sh);
	endfunction : filt_limit

	// One nibble of filter: returns {count, samples, filtered}
	// A bit moves only when two samples one check time apart agree,
	// so a pulse no wider than the check time can never pass.
	function automatic logic [22:0] group_filt(
		input logic [2:0] code,
		input logic [14:0] cnt,
		input logic [3:0] din,
		input logic [3:0] samp,
		input logic [3:0] filt
	);
		logic [3:0] diff;
		logic [3:0] nf;
		diff = din ^ samp;
		nf = (~diff & din) | (diff & filt);
		if (code == 3'h0) begin
			return {15'h0000, din, din};
		end else if (cnt >= 15'(filt_limit(code) - 15'h0001)) begin
			return {15'h0000, din, nf};
		end else begin
			return {15'(cnt + 15'h0001), samp, filt};
		end
	endfunction : group_filt

	// Pins taking part in the key-entry reset
	function automatic logic [3:0] key_mask(input logic [1:0] sel);
		case (sel)
			2'h3: return 4'hF;
			2'h2: return 4'h7;
			2'h1: return 4'h3;
			default: return 4'h0;
		endcase
	endfunction : key_mask

	// ------------------------------------------------------------
	// State and combinational helpers
	// ------------------------------------------------------------
	pedkr_pkg::pedkr_state_s st_ff;
	pedkr_pkg::pedkr_state_s nxt_st;
	logic [7:0] in0;
	logic [7:0] rise;
	logic [7:0] fall;
	logic [7:0] hit;
	logic [7:0] clr;
	logic [3:0] kmask;

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb begin
		nxt_st = st_ff;
		clr = 8'h00;

		// Synchronisers; first stage feeds only the second
		nxt_st.s1_p0 = p0_pin_in;
		nxt_st.s2_p0 = st_ff.s1_p0;
		nxt_st.s1_p1 = p1_pin_in;
		nxt_st.s2_p1 = st_ff.s1_p1;

		// Disabled inputs look low and so make no edges
		in0 = st_ff.s2_p0 & st_ff.ien0;

		// Chattering filter per nibble
		{nxt_st.cnt_lo, nxt_st.samp[3:0], nxt_st.filt[3:0]} = group_filt(
			st_ff.chat[`PEDKR_CHAT_LO_POS +: 3], st_ff.cnt_lo,
			in0[3:0], st_ff.samp[3:0], st_ff.filt[3:0]);
		{nxt_st.cnt_hi, nxt_st.samp[7:4], nxt_st.filt[7:4]} = group_filt(
			st_ff.chat[`PEDKR_CHAT_HI_POS +: 3], st_ff.cnt_hi,
			in0[7:4], st_ff.samp[7:4], st_ff.filt[7:4]);

		// Edge detection on the filtered level
		rise = nxt_st.filt & ~st_ff.filt;
		fall = ~nxt_st.filt & st_ff.filt;
		hit = (rise & ~st_ff.edge_sel) | (fall & st_ff.edge_sel);

		// Register writes; input data addresses are not decoded here
		if (bus_wr) begin
			case (bus_addr)
				`PEDKR_OFS_PORT0_OUTPUT_VALUE: nxt_st.out0 = bus_wdata;
				`PEDKR_OFS_PORT0_DRIVE_ENABLE: nxt_st.oen0 = bus_wdata;
				`PEDKR_OFS_PORT0_PULLUP_ENABLE: nxt_st.pu0 = bus_wdata;
				`PEDKR_OFS_P0_IE: nxt_st.ie = bus_wdata;
				`PEDKR_OFS_PORT0_IRQ_POLARITY: nxt_st.edge_sel = bus_wdata;
				`PEDKR_OFS_P0_PEND: clr = bus_wdata;
				`PEDKR_OFS_PORT0_DEBOUNCE_CTRL: nxt_st.chat = bus_wdata & 8'h77;
				`PEDKR_OFS_P0_KEY: nxt_st.key_sel = bus_wdata[1:0];
				`PEDKR_OFS_PORT0_SENSE_ENABLE: nxt_st.ien0 = bus_wdata;
				`PEDKR_OFS_PORT1_OUTPUT_VALUE: nxt_st.out1 = bus_wdata[3:0];
				`PEDKR_OFS_PORT1_DRIVE_ENABLE: nxt_st.oen1 = bus_wdata[3:0];
				`PEDKR_OFS_PORT1_PULLUP_ENABLE: nxt_st.pu1 = bus_wdata[3:0];
				`PEDKR_OFS_PORT1_SENSE_ENABLE: nxt_st.ien1 = bus_wdata[3:0];
				`PEDKR_OFS_MUX0: nxt_st.mux0 = bus_wdata;
				`PEDKR_OFS_MUX1: nxt_st.mux1 = bus_wdata;
				`PEDKR_OFS_MUX2: nxt_st.mux2 = bus_wdata;
				default: nxt_st.out0 = st_ff.out0;
			endcase
		end

		// Pending flags: a new edge wins over a same-cycle clear
		nxt_st.pend = (st_ff.pend & ~clr) | hit;

		// Register reads, data valid only in the following cycle
		nxt_st.rdata = 8'h00;
		if (bus_rd) begin
			case (bus_addr)
				`PEDKR_OFS_PORT0_INPUT_LEVEL: nxt_st.rdata = st_ff.s2_p0 & st_ff.ien0;
				`PEDKR_OFS_PORT0_OUTPUT_VALUE: nxt_st.rdata = st_ff.out0;
				`PEDKR_OFS_PORT0_DRIVE_ENABLE: nxt_st.rdata = st_ff.oen0;
				`PEDKR_OFS_PORT0_PULLUP_ENABLE: nxt_st.rdata = st_ff.pu0;
				`PEDKR_OFS_P0_IE: nxt_st.rdata = st_ff.ie;
				`PEDKR_OFS_PORT0_IRQ_POLARITY: nxt_st.rdata = st_ff.edge_sel;
				`PEDKR_OFS_P0_PEND: nxt_st.rdata = st_ff.pend;
				`PEDKR_OFS_PORT0_DEBOUNCE_CTRL: nxt_st.rdata = st_ff.chat;
				`PEDKR_OFS_P0_KEY: nxt_st.rdata = {6'h00, st_ff.key_sel};
				`PEDKR_OFS_PORT0_SENSE_ENABLE: nxt_st.rdata = st_ff.ien0;
				`PEDKR_OFS_PORT1_INPUT_LEVEL: nxt_st.rdata = {4'h0, st_ff.s2_p1 & st_ff.ien1};
				`PEDKR_OFS_PORT1_OUTPUT_VALUE: nxt_st.rdata = {4'h0, st_ff.out1};
				`PEDKR_OFS_PORT1_DRIVE_ENABLE: nxt_st.rdata = {4'h0, st_ff.oen1};
				`PEDKR_OFS_PORT1_PULLUP_ENABLE: nxt_st.rdata = {4'h0, st_ff.pu1};
				`PEDKR_OFS_PORT1_SENSE_ENABLE: nxt_st.rdata = {4'h0, st_ff.ien1};
				`PEDKR_OFS_MUX0: nxt_st.rdata = st_ff.mux0;
				`PEDKR_OFS_MUX1: nxt_st.rdata = st_ff.mux1;
				`PEDKR_OFS_MUX2: nxt_st.rdata = st_ff.mux2;
				default: nxt_st.rdata = 8'h00;
			endcase
		end

		// Key-entry reset uses the raw level so a disabled input
		// cannot fake a key press
		kmask = key_mask(st_ff.key_sel);
		nxt_st.keyrst = (kmask != 4'h0) && ((st_ff.s2_p0[3:0] & kmask) == 4'h0);
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_ff <= pedkr_pkg::PEDKR_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------

	// Pin drive; pull-up is dropped whenever the pin drives
	assign p0_pin_out = st_ff.out0;
	assign p0_pin_oe_n = ~st_ff.oen0;
	assign p0_pullup_on = st_ff.pu0 & ~st_ff.oen0;
	assign p1_pin_out = st_ff.out1;
	assign p1_pin_oe_n = ~st_ff.oen1;
	assign p1_pullup_on = st_ff.pu1 & ~st_ff.oen1;

	// Single merged request, visible with the flag itself
	assign irq_req = |(st_ff.pend & st_ff.ie);
	assign key_reset_req = st_ff.keyrst;
	assign bus_rdata = st_ff.rdata;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);

	// Masked flags never reach the request line
	a_mask_blocks_irq: assert property ((st_ff.ie == 8'h00) |-> !irq_req)
		else $error("request with all pins masked");

	// Enabled set flag shows on the request in the same cycle
	a_flag_raises_irq: assert property ((st_ff.ie[5] && st_ff.pend[5]) |-> irq_req)
		else $error("enabled pending flag without request");

	// Rising filtered level sets the flag in rising mode
	a_rise_sets_flag: assert property (($rose(st_ff.filt[0]) && !$past(st_ff.edge_sel[0]))
		|-> st_ff.pend[0])
		else $error("rising edge did not set flag");

	// Falling filtered level sets the flag in falling mode
	a_fall_sets_flag: assert property (($fell(st_ff.filt[6]) && $past(st_ff.edge_sel[6]))
		|-> st_ff.pend[6])
		else $error("falling edge did not set flag");

	// Writing one clears unless a new edge arrives
	a_one_clears: assert property ((bus_wr && bus_addr == `PEDKR_OFS_P0_PEND && bus_wdata[1])
		|=> (!st_ff.pend[1] || $changed(st_ff.filt[1])))
		else $error("write one did not clear flag");

	// Writing zero keeps a set flag
	a_zero_keeps: assert property ((bus_wr && bus_addr == `PEDKR_OFS_P0_PEND && !bus_wdata[2]
		&& st_ff.pend[2]) |=> st_ff.pend[2])
		else $error("write zero cleared flag");

	// With the filter off the level follows the input one cycle later
	a_filter_off_pass: assert property ((st_ff.chat[2:0] == 3'h0)
		|=> (st_ff.filt[3:0] == $past(st_ff.s2_p0[3:0] & st_ff.ien0[3:0])))
		else $error("unfiltered level mismatch");

	// With the filter on the level moves only on a sample tick
	a_filter_tick_only: assert property (($past(st_ff.chat[6:4]) != 3'h0 && $changed(st_ff.filt[7:4]))
		|-> (st_ff.cnt_hi == 15'h0000))
		else $error("filtered level moved between samples");

	// All four pins low with full selection requests reset
	a_key_all_low: assert property ((st_ff.key_sel == 2'h3 && st_ff.s2_p0[3:0] == 4'h0)
		|=> key_reset_req)
		else $error("key reset not requested");

	// Key reset off never requests
	a_key_off: assert property ((st_ff.key_sel == 2'h0) |=> !key_reset_req)
		else $error("key reset while disabled");

	// Input read-back gated by the sense enable
	a_readback_gate: assert property ((bus_rd && bus_addr == `PEDKR_OFS_PORT0_INPUT_LEVEL)
		|=> (bus_rdata == $past(st_ff.s2_p0 & st_ff.ien0)))
		else $error("input read-back mismatch");

	// Port 1 upper bits always read zero
	a_p1_upper_zero: assert property ((bus_rd && bus_addr[15:4] == 12'h521) |=> (bus_rdata[7:4] == 4'h0))
		else $error("port 1 reserved bits not zero");

	// Writing input data leaves the drive state untouched
	a_in_read_only: assert property ((bus_wr && bus_addr == `PEDKR_OFS_PORT0_INPUT_LEVEL)
		|=> ($stable(st_ff.out0) && $stable(st_ff.oen0)))
		else $error("write to input data changed state");

	// Synchroniser takes two edges to reach the second stage
	a_sync_two_flop: assert property (1'b1 |-> ##2 (st_ff.s2_p0 == $past(p0_pin_in, 2)))
		else $error("synchroniser latency wrong");

endmodule : pedkr_port

/* File: pedkr_key_model.sv */
// Far side of one port: key switches to ground, pull-ups and wiring.
// Assumes active-low pin enables and a pull-up output from the port.
`timescale 1ns/1ps

module pedkr_key_model #(
	parameter int W = 8
) (
	input wire logic ref_clk,
	input wire logic [W-1:0] key_down,
	input wire logic [W-1:0] pin_out,
	input wire logic [W-1:0] pin_oe_n,
	input wire logic [W-1:0] pullup_on,
	output logic [W-1:0] pin_level
);
	logic [W-1:0] float_ff = '0;

	// Floating pins wander every cycle so no check can lean on them
	always_ff @(posedge ref_clk) begin
		float_ff <= ~float_ff;
	end

	// Driven pin wins; a pressed key grounds, a pull-up lifts the rest
	always_comb begin
		for (int i = 0; i < W; i++) begin
			if (!pin_oe_n[i]) pin_level[i] = pin_out[i];
			else if (key_down[i]) pin_level[i] = 1'b0;
			else if (pullup_on[i]) pin_level[i] = 1'b1;
			else pin_level[i] = float_ff[i];
		end
	end
endmodule : pedkr_key_model

/* File: pedkr_port_tb_top.sv */
// Self-checking bench for the two-port block with key models on the pins.
// Assumes a one-cycle register port and a short filter base of 4 cycles.
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin n_fail++; \
	$display("wrong value %s expected %h seen %h", nm, ex, gt); end end

module pedkr_port_tb_top;
	localparam int BASE = 4;
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [15:0] bus_addr = 16'h0000;
	logic [7:0] bus_wdata = 8'h00;
	logic bus_wr = 1'b0;
	logic bus_rd = 1'b0;
	logic [7:0] bus_rdata, p0_pin_in, p0_pin_out, p0_pin_oe_n, p0_pullup_on, got, o, e, s;
	logic [3:0] p1_pin_in, p1_pin_out, p1_pin_oe_n, p1_pullup_on;
	logic irq_req, key_reset_req;
	logic [7:0] key0 = 8'h00;
	logic [3:0] key1 = 4'h0;
	logic [31:0] seed = 32'hBF73;
	logic [15:0] ra[14] = '{16'h5201, 16'h5202, 16'h5203, 16'h5205, 16'h5206, 16'h5207, 16'h5208,
		16'h5209, 16'h520A, 16'h5211, 16'h5212, 16'h5213, 16'h521A, 16'h5204};
	logic [7:0] rv[14] = '{8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00,
		8'h0F, 8'h0F, 8'h00};
	logic [15:0] ma[15] = '{16'h5201, 16'h5202, 16'h5203, 16'h5205, 16'h5206, 16'h5208, 16'h5209,
		16'h520A, 16'h5211, 16'h5212, 16'h5213, 16'h521A, 16'h52A0, 16'h52A1, 16'h52A2};
	logic [7:0] mk[15] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h77, 8'h03, 8'hFF, 8'h0F, 8'h0F,
		8'h0F, 8'h0F, 8'hFF, 8'hFF, 8'hFF};
	logic [7:0] wv[15];
	int n_fail = 0;
	int n_tests = 0;

	pedkr_port #(.FILT_BASE_CYC(BASE)) i_pedkr_port (.ref_clk(ref_clk), .arst_n(arst_n),
		.bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
		.bus_rdata(bus_rdata), .p0_pin_in(p0_pin_in), .p0_pin_out(p0_pin_out),
		.p0_pin_oe_n(p0_pin_oe_n), .p0_pullup_on(p0_pullup_on), .p1_pin_in(p1_pin_in),
		.p1_pin_out(p1_pin_out), .p1_pin_oe_n(p1_pin_oe_n), .p1_pullup_on(p1_pullup_on),
		.irq_req(irq_req), .key_reset_req(key_reset_req));
	pedkr_key_model #(.W(8)) i_pedkr_key_model_p0 (.ref_clk(ref_clk), .key_down(key0),
		.pin_out(p0_pin_out), .pin_oe_n(p0_pin_oe_n), .pullup_on(p0_pullup_on), .pin_level(p0_pin_in));
	pedkr_key_model #(.W(4)) i_pedkr_key_model_p1 (.ref_clk(ref_clk), .key_down(key1),
		.pin_out(p1_pin_out), .pin_oe_n(p1_pin_oe_n), .pullup_on(p1_pullup_on), .pin_level(p1_pin_in));

	// ----
	// Clock, bus tasks and expectations
	// ----
	// Free-running 10 MHz clock
	initial begin
		forever #50 ref_clk = ~ref_clk;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr

	// Request only when every selected pin reads low
	function automatic logic exp_key(input logic [1:0] sel, input logic [3:0] lvl);
		logic [3:0] m;
		m = (sel == 2'h3) ? 4'hF : (sel == 2'h2) ? 4'h7 : 4'h3;
		return (sel != 2'h0) && ((lvl & m) == 4'h0);
	endfunction : exp_key

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : cyc

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		bus_wr <= 1'b1;
		bus_addr <= a;
		bus_wdata <= d;
		@(posedge ref_clk);
		bus_wr <= 1'b0;
	endtask : wr

	// Read data stands only in the cycle after the strobe
	task automatic rdc(input logic [15:0] a, input logic [7:0] ex);
		@(posedge ref_clk);
		bus_rd <= 1'b1;
		bus_addr <= a;
		@(posedge ref_clk);
		bus_rd <= 1'b0;
		#1;
		`CHK("read data", ex, bus_rdata)
	endtask : rdc

	// Bounded wait for the request line
	task automatic wait_irq(input int lim);
		int i;
		for (i = 0; i < lim && irq_req !== 1'b1; i++) begin
			@(posedge ref_clk);
			#1;
		end
		if (i == lim) begin
			n_fail++;
			$display("wrong value irq wait expected 1 seen %b", irq_req);
			summarize();
		end
	endtask : wait_irq

	task automatic summarize;
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : summarize

	// ----
	// Main sequence
	// ----
	// Reset values, register access, pins, edges, filter, key reset
	initial begin
		cyc(5);
		arst_n <= 1'b1;
		`CHK("oe_n", 8'hFF, p0_pin_oe_n)
		`CHK("pullup", 8'hFF, p0_pullup_on)
		foreach (ra[i]) rdc(ra[i], rv[i]);
		$display("test reset values done");
		foreach (ma[i]) begin
			seed = lfsr(seed);
			wv[i] = seed[7:0] & mk[i];
			wr(ma[i], wv[i]);
		end
		wr(16'h5200, ~wv[0]);
		wr(16'h5210, ~wv[8]);
		foreach (ma[i]) rdc(ma[i], wv[i] & mk[i]);
		foreach (ra[i]) wr(ra[i], rv[i]);
		wr(16'h5207, 8'hFF);
		$display("test register access done");
		for (int k = 0; k < 6; k++) begin
			seed = lfsr(seed);
			wr(16'h5201, seed[7:0]);
			wr(16'h5202, seed[15:8]);
			wr(16'h520A, seed[23:16]);
			wr(16'h5211, {4'h0, seed[3:0]});
			wr(16'h5212, {4'h0, seed[11:8]});
			wr(16'h521A, {4'h0, seed[19:16]});
			key0 <= seed[31:24] & ~seed[15:8];
			key1 <= seed[27:24] & ~seed[11:8];
			cyc(4);
			o = (seed[7:0] & seed[15:8]) | (~seed[15:8] & ~seed[31:24]);
			`CHK("port0_output_value", seed[7:0], p0_pin_out)
			`CHK("p0 oe_n", ~seed[15:8], p0_pin_oe_n)
			`CHK("p1 oe_n", ~seed[11:8], p1_pin_oe_n)
			`CHK("port1_output_value", seed[3:0], p1_pin_out)
			`CHK("p0 pullup", ~seed[15:8], p0_pullup_on)
			`CHK("p1 pullup", ~seed[11:8], p1_pullup_on)
			`CHK("irq masked", 1'b0, irq_req)
			rdc(16'h5200, o & seed[23:16]);
			rdc(16'h5210, {4'h0, o[3:0] & seed[19:16]});
		end
		foreach (ra[i]) wr(ra[i], rv[i]);
		key0 <= 8'h00;
		key1 <= 4'h0;
		$display("test pin read-back done");
		for (int b = 0; b < 8; b++) begin
			for (int f = 0; f < 2; f++) begin
				s = 8'h01 << b;
				e = f ? s : 8'h00;
				wr(16'h5206, e);
				key0 <= f ? 8'h00 : s;
				cyc(4);
				wr(16'h5207, 8'hFF);
				wr(16'h5205, s);
				key0 <= f ? s : 8'h00;
				cyc(4);
				`CHK("irq", 1'b1, irq_req)
				rdc(16'h5207, s);
				wr(16'h5205, 8'h00);
				#1;
				`CHK("irq off", 1'b0, irq_req)
				wr(16'h5207, ~s);
				rdc(16'h5207, s);
				wr(16'h5207, s);
				rdc(16'h5207, 8'h00);
				key0 <= f ? 8'h00 : s;
				cyc(4);
				rdc(16'h5207, 8'h00);
			end
		end
		$display("test edge interrupts done");
		for (int c = 1; c < 3; c++) begin
			wr(16'h5205, 8'h00);
			wr(16'h5208, {1'b0, c[2:0], 1'b0, c[2:0]});
			key0 <= 8'h11;
			cyc(3 * (BASE << (c - 1)) + 10);
			wr(16'h5207, 8'hFF);
			wr(16'h5205, 8'h11);
			key0 <= 8'h00;
			cyc(BASE << (c - 1));
			key0 <= 8'h11;
			cyc(3 * (BASE << (c - 1)) + 6);
			rdc(16'h5207, 8'h00);
			key0 <= 8'h00;
			wait_irq(2 * (BASE << (c - 1)) + 12);
			cyc(2);
			rdc(16'h5207, 8'h11);
			wr(16'h5205, 8'h00);
			wr(16'h5208, 8'h00);
			wr(16'h5207, 8'hFF);
		end
		$display("test filter done");
		for (int sl = 0; sl < 4; sl++) begin
			wr(16'h5209, 8'(sl));
			for (int k = 0; k < 16; k++) begin
				key0 <= {4'h0, 4'(k)};
				cyc(5);
				`CHK("key reset", exp_key(2'(sl), ~4'(k)), key_reset_req)
			end
		end
		$display("test key reset done");
		summarize();
	end
endmodule : pedkr_port_tb_top
